// file: core/ksi_key_manager_regs.sv
// Purpose: Register side of the key manager: event flags, interrupt enables, status, slot select.
// Assumes: Event and access inputs are one-cycle pulses on core_clk; APB master obeys protocol.
// Notes: One access cycle per transfer; read data is captured in the setup cycle.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

// Function
// [R1] Read-write enable register: bit0 push done, bit1 revoked, bit2 fault; 1 enables.
// [R2] Set-enable writes of one enable bits; zeros ignored; reads return enable state.
// [R3] Clear-enable writes of one disable bits; zeros ignored; reads return enable state.
// [R4] Read-only pending register shows one per event while that interrupt is pending.
// [R5] Enable and pending state come out of reset all zero.
// [R6] Each slot-select write resets status; later operations set status bits again.
// [R7] Slot-select holds the slot index used for key reads and pushes.
// [R8] Push-done event raised only after the 128-bit secure write completes.
// [R9] Blocked bit on foreign slot, failed select or violation; selected bit on success.
// [R10] Interrupt high while any event flag is latched and enabled; pending is flag and enable.
module ksi_key_manager_regs (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ksi_pkg::ADDR_W-1:0] paddr,
  input wire logic [ksi_pkg::DATA_W-1:0] pwdata,
  output logic [ksi_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ksi_pkg::ksi_evt_s evt_in,
  input wire ksi_pkg::ksi_acc_s acc_in,
  output logic push_slot_task,
  output logic [ksi_pkg::SLOT_W-1:0] slot_select_idx,
  output logic irq
);
  import ksi_pkg::*;

  ksi_apb_e state_reg;
  ksi_apb_e state_next;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [EVT_W-1:0] enable_reg;
  logic [EVT_W-1:0] enable_next;
  logic [EVT_W-1:0] flags_reg;
  logic [EVT_W-1:0] flags_next;
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] status_next;
  logic [SLOT_W-1:0] slot_reg;
  logic [SLOT_W-1:0] slot_next;
  logic task_reg;
  logic irq_reg;

  // Phase decode
  wire setup_phase = psel & ~penable;
  wire wr_commit = psel & penable & pwrite & pready_reg;

  // Address decode
  wire hit_task = (paddr == OFS_PUSH_TASK);
  wire hit_evt_done = (paddr == OFS_EVT_DONE);
  wire hit_evt_rev = (paddr == OFS_EVT_REVOKED);
  wire hit_evt_fault = (paddr == OFS_EVT_FAULT);
  wire hit_evt_clr = (paddr == OFS_EVT_CLEAR);
  wire hit_en = (paddr == OFS_IRQ_ENABLE);
  wire hit_en_set = (paddr == OFS_IRQ_ENABLE_SET);
  wire hit_en_clr = (paddr == OFS_IRQ_ENABLE_CLEAR);
  wire hit_pend = (paddr == OFS_IRQ_PENDING);
  wire hit_status = (paddr == OFS_OP_STATUS);
  wire hit_slot = (paddr == OFS_SLOT_SELECT);
  wire hit_any = hit_task | hit_evt_done | hit_evt_rev | hit_evt_fault | hit_evt_clr |
                 hit_en | hit_en_set | hit_en_clr | hit_pend | hit_status | hit_slot;

  // Write strobes
  wire wr_task = wr_commit & hit_task;
  wire wr_evt_clr = wr_commit & hit_evt_clr;
  wire wr_en = wr_commit & hit_en;
  wire wr_en_set = wr_commit & hit_en_set;
  wire wr_en_clr = wr_commit & hit_en_clr;
  wire wr_slot = wr_commit & hit_slot;

  wire [EVT_W-1:0] wdata_evt = pwdata[EVT_W-1:0];
  wire [EVT_W-1:0] evt_pulse = evt_in;
  wire [EVT_W-1:0] evt_clr_mask = wr_evt_clr ? wdata_evt : RST_FLAGS;
  wire [STAT_W-1:0] acc_pulse = acc_in;

  // Pending is a pure view, never stored, so it cannot drift from its sources
  wire [EVT_W-1:0] pending = flags_reg & enable_reg; // [R10]

  // Enable update; a plain write replaces, set and clear only touch one bits
  assign enable_next = wr_en ? wdata_evt : // [R1]
                       wr_en_set ? (enable_reg | wdata_evt) : // [R2]
                       wr_en_clr ? (enable_reg & ~wdata_evt) : // [R3]
                       enable_reg;

  // New event wins over a clear in the same cycle
  assign flags_next = (flags_reg & ~evt_clr_mask) | evt_pulse; // [R8]

  // Slot-select write wipes status, but an outcome in that cycle survives
  assign status_next = wr_slot ? acc_pulse : (status_reg | acc_pulse); // [R6] [R9]

  assign slot_next = wr_slot ? pwdata[SLOT_W-1:0] : slot_reg; // [R7]

  assign state_next = setup_phase ? ST_ACCESS : ST_IDLE;

  // Read mux; unused upper bits read as zero
  wire [DATA_W-1:0] rd_enable = {{(DATA_W-EVT_W){1'b0}}, enable_reg}; // [R2] [R3]
  wire [DATA_W-1:0] rd_pend = {{(DATA_W-EVT_W){1'b0}}, pending}; // [R4]
  wire [DATA_W-1:0] rd_status = {{(DATA_W-STAT_W){1'b0}}, status_reg};
  wire [DATA_W-1:0] rd_slot = {{(DATA_W-SLOT_W){1'b0}}, slot_reg};
  wire [DATA_W-1:0] rd_done = {{(DATA_W-1){1'b0}}, flags_reg[BIT_PUSH_DONE]};
  wire [DATA_W-1:0] rd_rev = {{(DATA_W-1){1'b0}}, flags_reg[BIT_REVOKED]};
  wire [DATA_W-1:0] rd_fault = {{(DATA_W-1){1'b0}}, flags_reg[BIT_FAULT]};
  wire [DATA_W-1:0] rdata_mux = (hit_en | hit_en_set | hit_en_clr) ? rd_enable :
                                hit_pend ? rd_pend :
                                hit_status ? rd_status :
                                hit_slot ? rd_slot :
                                hit_evt_done ? rd_done :
                                hit_evt_rev ? rd_rev :
                                hit_evt_fault ? rd_fault :
                                DATA_ZERO;
  wire [DATA_W-1:0] prdata_next = (setup_phase & ~pwrite) ? rdata_mux : DATA_ZERO;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= DATA_ZERO;
    end else begin
      state_reg <= state_next;
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~hit_any;
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_reg <= RST_ENABLE; // [R5]
      flags_reg <= RST_FLAGS; // [R5]
      status_reg <= RST_STATUS;
      slot_reg <= RST_SLOT;
      task_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      flags_reg <= flags_next;
      status_reg <= status_next;
      slot_reg <= slot_next;
      task_reg <= wr_task & pwdata[BIT_TASK];
      irq_reg <= |(flags_next & enable_next); // [R10]
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign push_slot_task = task_reg;
  assign slot_select_idx = slot_reg;
  assign irq = irq_reg;

  // Checks kept beside the logic they watch

  en_write_a: assert property ( // [R1]
    @(posedge core_clk) disable iff (srst)
    wr_en |=> enable_reg == $past(wdata_evt)
  ) else $error("enable register did not take written value");

  en_set_a: assert property ( // [R2]
    @(posedge core_clk) disable iff (srst)
    wr_en_set |=> enable_reg == ($past(enable_reg) | $past(wdata_evt))
  ) else $error("set-enable did not set exactly the written ones");

  en_clear_a: assert property ( // [R3]
    @(posedge core_clk) disable iff (srst)
    wr_en_clr |=> enable_reg == ($past(enable_reg) & ~$past(wdata_evt))
  ) else $error("clear-enable did not clear exactly the written ones");

  pend_read_a: assert property ( // [R4]
    @(posedge core_clk) disable iff (srst)
    (setup_phase && !pwrite && hit_pend) |=>
      (prdata[EVT_W-1:0] == $past(flags_reg & enable_reg)) &&
      (prdata[DATA_W-1:EVT_W] == '0) && pready
  ) else $error("pending read returned wrong value");

  reset_zero_a: assert property ( // [R5]
    @(posedge core_clk)
    srst |=> (enable_reg == RST_ENABLE) && (flags_reg == RST_FLAGS) && !irq
  ) else $error("enable or flags not zero after reset");

  status_wipe_a: assert property ( // [R6]
    @(posedge core_clk) disable iff (srst)
    (wr_slot && acc_pulse == RST_STATUS) |=> status_reg == RST_STATUS
  ) else $error("status not cleared by slot-select write");

  slot_hold_a: assert property ( // [R7]
    @(posedge core_clk) disable iff (srst)
    !wr_slot |=> $stable(slot_select_idx)
  ) else $error("slot index changed without a write");

  slot_take_a: assert property ( // [R7]
    @(posedge core_clk) disable iff (srst)
    wr_slot |=> slot_select_idx == $past(pwdata[SLOT_W-1:0])
  ) else $error("slot index did not take written value");

  push_done_a: assert property ( // [R8]
    @(posedge core_clk) disable iff (srst)
    evt_in.slot_push_done |=> flags_reg[BIT_PUSH_DONE]
  ) else $error("push-done flag not latched");

  blocked_set_a: assert property ( // [R9]
    @(posedge core_clk) disable iff (srst)
    acc_in.blocked |=> status_reg[BIT_BLOCKED] ##1 (status_reg[BIT_BLOCKED] || $past(wr_slot))
  ) else $error("blocked status bit lost without slot write");

  irq_level_a: assert property ( // [R10]
    @(posedge core_clk) disable iff (srst)
    ##1 (irq == |$past(flags_next & enable_next))
  ) else $error("interrupt does not follow flag and enable");

  irq_quiet_a: assert property ( // [R10]
    @(posedge core_clk) disable iff (srst)
    (enable_reg == RST_ENABLE) |-> !(|pending)
  ) else $error("pending with all enables off");

  task_pulse_a: assert property ( // [R7]
    @(posedge core_clk) disable iff (srst)
    push_slot_task |=> !push_slot_task
  ) else $error("push task strobe longer than one cycle");

  // Bus phase tracking; the state register must agree with the ready flop
  state_track_a: assert property (
    @(posedge core_clk) disable iff (srst)
    pready == (state_reg == ST_ACCESS)
  ) else $error("phase state and ready disagree");

  ready_one_a: assert property (
    @(posedge core_clk) disable iff (srst)
    pready |=> !pready
  ) else $error("ready held longer than one access cycle");

  err_unmapped_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (setup_phase && !hit_any) |=> pslverr && pready
  ) else $error("unmapped access without error");

  err_mapped_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (setup_phase && hit_any) |=> !pslverr
  ) else $error("mapped access flagged as error");

  rdata_idle_a: assert property (
    @(posedge core_clk) disable iff (srst)
    !pready |-> prdata == DATA_ZERO
  ) else $error("read data driven outside access");

  wr_rdata_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (setup_phase && pwrite) |=> prdata == DATA_ZERO
  ) else $error("read data driven during write");

  en_read_a: assert property ( // [R2]
    @(posedge core_clk) disable iff (srst)
    (setup_phase && !pwrite && (hit_en_set || hit_en_clr)) |=>
      prdata[EVT_W-1:0] == $past(enable_reg)
  ) else $error("set or clear view does not show enables");

  en_hold_a: assert property ( // [R1]
    @(posedge core_clk) disable iff (srst)
    !(wr_en || wr_en_set || wr_en_clr) |=> $stable(enable_reg)
  ) else $error("enables changed without a write");

  pend_ro_a: assert property ( // [R4]
    @(posedge core_clk) disable iff (srst)
    (wr_commit && hit_pend && evt_pulse == RST_FLAGS) |=>
      $stable(flags_reg) && $stable(enable_reg)
  ) else $error("write to pending register changed state");

  flag_hold_a: assert property ( // [R8]
    @(posedge core_clk) disable iff (srst)
    (!wr_evt_clr && evt_pulse == RST_FLAGS) |=> $stable(flags_reg)
  ) else $error("event flags changed without cause");

  flag_set_wins_a: assert property ( // [R8]
    @(posedge core_clk) disable iff (srst)
    wr_evt_clr |=> (flags_reg & $past(evt_pulse)) == $past(evt_pulse)
  ) else $error("clear swallowed a same-cycle event");

  flag_clear_a: assert property ( // [R10]
    @(posedge core_clk) disable iff (srst)
    (wr_evt_clr && evt_pulse == RST_FLAGS) |=> (flags_reg & $past(wdata_evt)) == RST_FLAGS
  ) else $error("event flag survived its clear");

  flag_read_a: assert property ( // [R8]
    @(posedge core_clk) disable iff (srst)
    (setup_phase && !pwrite && hit_evt_done) |=> prdata[0] == $past(flags_reg[BIT_PUSH_DONE])
  ) else $error("push-done flag read wrong");

  selected_set_a: assert property ( // [R9]
    @(posedge core_clk) disable iff (srst)
    acc_in.selected |=> status_reg[BIT_SELECTED]
  ) else $error("selected status bit not set");

  status_hold_a: assert property ( // [R6]
    @(posedge core_clk) disable iff (srst)
    (!wr_slot && acc_pulse == RST_STATUS) |=> $stable(status_reg)
  ) else $error("status changed without cause");

  status_keep_a: assert property ( // [R9]
    @(posedge core_clk) disable iff (srst)
    wr_slot |=> status_reg == $past(acc_pulse)
  ) else $error("slot write lost a same-cycle outcome");

  status_read_a: assert property ( // [R6]
    @(posedge core_clk) disable iff (srst)
    (setup_phase && !pwrite && hit_status) |=> prdata[STAT_W-1:0] == $past(status_reg)
  ) else $error("status read wrong");

  slot_read_a: assert property ( // [R7]
    @(posedge core_clk) disable iff (srst)
    (setup_phase && !pwrite && hit_slot) |=> prdata[SLOT_W-1:0] == $past(slot_reg)
  ) else $error("slot select read wrong");

  irq_on_a: assert property ( // [R10]
    @(posedge core_clk) disable iff (srst)
    irq == (|pending)
  ) else $error("interrupt differs from pending view");

  task_take_a: assert property ( // [R7]
    @(posedge core_clk) disable iff (srst)
    (wr_task && pwdata[BIT_TASK]) |=> push_slot_task
  ) else $error("push task strobe missing");

  task_quiet_a: assert property ( // [R7]
    @(posedge core_clk) disable iff (srst)
    !(wr_task && pwdata[BIT_TASK]) |=> !push_slot_task
  ) else $error("push task strobe without a write");

  reset_out_a: assert property ( // [R5]
    @(posedge core_clk)
    srst |=> !pready && !pslverr && !push_slot_task && (prdata == DATA_ZERO)
  ) else $error("bus outputs not quiet after reset");

endmodule : ksi_key_manager_regs

// file: core/ksi_pkg.sv
// Purpose: Shared constants and carriers for the key slot interrupt/status block.
// Assumes: APB slave with 32-bit data, byte addresses, 12 address bits decoded.
// Notes: Offsets are byte addresses of aligned words.
package ksi_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int EVT_W = 3;
  localparam int STAT_W = 2;
  localparam int SLOT_W = 8;

  localparam logic [ADDR_W-1:0] OFS_PUSH_TASK = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_EVT_DONE = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_EVT_REVOKED = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_EVT_FAULT = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 12'h110;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h300;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET = 12'h304;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [ADDR_W-1:0] OFS_IRQ_PENDING = 12'h30C;
  localparam logic [ADDR_W-1:0] OFS_OP_STATUS = 12'h40C;
  localparam logic [ADDR_W-1:0] OFS_SLOT_SELECT = 12'h500;

  localparam int BIT_PUSH_DONE = 0;
  localparam int BIT_REVOKED = 1;
  localparam int BIT_FAULT = 2;
  localparam int BIT_TASK = 0;
  localparam int BIT_EVT_FLAG = 0;
  localparam int BIT_SELECTED = 0;
  localparam int BIT_BLOCKED = 1;

  localparam logic [EVT_W-1:0] RST_ENABLE = 3'h0;
  localparam logic [EVT_W-1:0] RST_FLAGS = 3'h0;
  localparam logic [STAT_W-1:0] RST_STATUS = 2'h0;
  localparam logic [SLOT_W-1:0] RST_SLOT = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Event pulses from the push engine; packed so done lands on bit 0
  typedef struct packed {
    logic slot_push_fault;
    logic slot_revoked_hit;
    logic slot_push_done;
  } ksi_evt_s;

  // Access outcome pulses from the key storage side
  typedef struct packed {
    logic blocked;
    logic selected;
  } ksi_acc_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } ksi_apb_e;

endpackage : ksi_pkg

// file: tb/ksi_key_manager_regs_tb.sv
// Purpose: Self-checking bench for the key manager register side over APB.
// Assumes: Registered one-cycle APB answer; events and access results are one-cycle pulses.
// Notes: Expected APB results queue up; a negedge monitor pops and compares them.
`timescale 1ns/1ps
module ksi_key_manager_regs_tb;
  import ksi_pkg::*;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, push_slot_task, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [SLOT_W-1:0] slot_select_idx, rnd;
  logic [2:0] e;
  ksi_evt_s evt;
  ksi_acc_s acc;
  logic [32:0] expq[$];
  int miscompares = 0;
  int tests_run = 0;
  int n;
  logic [11:0] n_regs[9] = '{12'h300, 12'h304, 12'h308, 12'h30C, 12'h40C, 12'h500,
                             12'h100, 12'h104, 12'h108};
  ksi_key_manager_regs DUT (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_in(evt), .acc_in(acc), .push_slot_task(push_slot_task),
    .slot_select_idx(slot_select_idx), .irq(irq));
  always #25 core_clk = ~core_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Full APB transfer; exp holds {pslverr, prdata} for the access cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    expq.push_back(exp);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(negedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      print_verdict();
    end
    @(posedge core_clk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask : rd
  task automatic pulse(input logic [2:0] ev, input logic [1:0] ac);
    @(posedge core_clk);
    evt <= ksi_evt_s'(ev); acc <= ksi_acc_s'(ac);
    @(posedge core_clk);
    evt <= ksi_evt_s'(3'h0); acc <= ksi_acc_s'(2'h0);
  endtask : pulse
  task automatic irq_is(input logic v);
    @(negedge core_clk);
    chk("irq", {32'h0, irq}, {32'h0, v});
  endtask : irq_is
  // Counts task pulses over a short window after a task write
  task automatic push(input logic [31:0] d, input int exp);
    int hits;
    hits = 0;
    wr(OFS_PUSH_TASK, d);
    repeat (4) begin
      @(negedge core_clk);
      if (push_slot_task === 1'b1) hits++;
    end
    chk("push_task", 33'(hits), 33'(exp));
  endtask : push
  always @(negedge core_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expq.size() == 0) chk("apb_extra", 33'h1, 33'h0);
      else chk("apb", {pslverr, prdata}, expq.pop_front());
    end
  end
  initial begin
    core_clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    evt = '0; acc = '0; rnd = 8'h22;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    foreach (n_regs[i]) rd(n_regs[i], 32'h0);
    irq_is(1'b0);
    $display("test reset done");
    wr(OFS_IRQ_ENABLE_SET, 32'h5); wr(OFS_IRQ_ENABLE_SET, 32'h0);
    rd(OFS_IRQ_ENABLE, 32'h5); rd(OFS_IRQ_ENABLE_CLEAR, 32'h5);
    wr(OFS_IRQ_ENABLE_CLEAR, 32'h1); wr(OFS_IRQ_ENABLE_CLEAR, 32'h0);
    rd(OFS_IRQ_ENABLE_SET, 32'h4);
    wr(OFS_IRQ_ENABLE, 32'hFFFF_FFFA); rd(OFS_IRQ_ENABLE_CLEAR, 32'h2);
    wr(OFS_IRQ_ENABLE, 32'h0);
    $display("test enables done");
    for (int i = 0; i < 3; i++) begin
      e = 3'h1 << i;
      pulse(e, 2'h0); rd(OFS_IRQ_PENDING, 32'h0); irq_is(1'b0);
      wr(OFS_IRQ_ENABLE_SET, {29'h0, e}); rd(OFS_IRQ_PENDING, {29'h0, e}); irq_is(1'b1);
      wr(OFS_IRQ_PENDING, 32'h0); rd(OFS_IRQ_PENDING, {29'h0, e});
      wr(OFS_IRQ_ENABLE_CLEAR, {29'h0, e}); irq_is(1'b0);
      wr(OFS_EVT_CLEAR, {29'h0, e}); wr(OFS_IRQ_ENABLE_SET, {29'h0, e});
      rd(OFS_IRQ_PENDING, 32'h0); irq_is(1'b0);
      wr(OFS_IRQ_ENABLE_CLEAR, 32'h7);
    end
    $display("test events done");
    pulse(3'h0, 2'h1); rd(OFS_OP_STATUS, 32'h1);
    pulse(3'h0, 2'h2); rd(OFS_OP_STATUS, 32'h3);
    repeat (3) begin
      rnd = lfsr(rnd);
      wr(OFS_SLOT_SELECT, {4{rnd}}); rd(OFS_OP_STATUS, 32'h0);
      rd(OFS_SLOT_SELECT, {24'h0, rnd});
      chk("slot_idx", {25'h0, slot_select_idx}, {25'h0, rnd});
      pulse(3'h0, 2'h2); rd(OFS_OP_STATUS, 32'h2);
    end
    $display("test status done");
    push(32'h1, 1); push(32'h0, 0);
    apb(1'b1, 12'h204, 32'h7, {1'b1, 32'h0});
    apb(1'b0, 12'hFFC, 32'h0, {1'b1, 32'h0});
    $display("test push and unmapped done");
    print_verdict();
  end
  initial begin
    #(50 * 20000);
    miscompares++;
    print_verdict();
  end
endmodule : ksi_key_manager_regs_tb
